// ---- hw/flash_row_erase_sequencer.sv ----
// Purpose: Row erase sequencer for on-chip program flash
// Assumes: Wishbone classic slave, synchronous high reset, clock enable
// Notes: Ack comes one cycle after the request is seen
module flash_row_erase_sequencer #(
   parameter int unsigned ERASE_CYCLES = flash_erase_pkg::ERASE_CYCLES
) (
   input wire logic SYS_CLK,
   input wire logic SRST,
   input wire logic CLK_EN,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   output logic CPU_STALL,
   output logic SLEEP_REQ,
   output logic ERASE_EN,
   output logic [14:0] ERASE_ROW,
   output logic ERASE_CFG_SPACE
);
   logic [7:0] addr_low_ff;
   logic [6:0] addr_high_ff;
   logic [7:0] control_ff;
   flash_erase_pkg::unlock_t unlock_ff;
   flash_erase_pkg::seq_t seq_ff;
   logic [21:0] count_ff;
   flash_erase_pkg::erase_req_t req_ff;
   logic ack_ff;
   logic [31:0] rdata_ff;
   logic stall_ff;
   logic erase_en_ff;

   logic req;
   logic wr_acc;
   logic wr_low;
   logic start_ok;
   logic start_wr;
   logic [7:0] nxt_control;
   logic [14:0] full_addr;

   function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
      hit = (adr[7:2] == ofs[7:2]);
   endfunction

   assign req = WB_CYC_I && WB_STB_I && !ack_ff;
   assign wr_acc = req && WB_WE_I;
   assign wr_low = wr_acc && WB_SEL_I[0];
   assign full_addr = {addr_high_ff, addr_low_ff};
   assign nxt_control = WB_DAT_I[7:0];
   assign start_wr = wr_low && hit(WB_ADR_I, flash_erase_pkg::OFS_CONTROL)
      && nxt_control[flash_erase_pkg::BIT_START]
      && !control_ff[flash_erase_pkg::BIT_START];
   assign start_ok = start_wr && (seq_ff == flash_erase_pkg::SEQ_IDLE)
      && nxt_control[flash_erase_pkg::BIT_MODIFY_EN]
      && control_ff[flash_erase_pkg::BIT_MODIFY_EN]
      && nxt_control[flash_erase_pkg::BIT_ROW_ERASE]
      && (unlock_ff == flash_erase_pkg::UNLOCK_OPEN);

   // Wishbone handshake, one wait cycle
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         ack_ff <= 1'b0;
      end else if (CLK_EN) begin
         ack_ff <= req;
      end
   end

   // Read data
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         rdata_ff <= 32'h0;
      end else if (CLK_EN && req) begin
         rdata_ff <= 32'h0;
         if (hit(WB_ADR_I, flash_erase_pkg::OFS_ADDR_LOW)) begin
            rdata_ff[7:0] <= addr_low_ff;
         end else if (hit(WB_ADR_I, flash_erase_pkg::OFS_ADDR_HIGH)) begin
            rdata_ff[6:0] <= addr_high_ff;
         end else if (hit(WB_ADR_I, flash_erase_pkg::OFS_CONTROL)) begin
            rdata_ff[7:0] <= control_ff;
         end
      end
   end

   // Address registers, frozen while busy
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         addr_low_ff <= flash_erase_pkg::ADDR_RESET;
         addr_high_ff <= 7'h0;
      end else if (CLK_EN && wr_low && seq_ff == flash_erase_pkg::SEQ_IDLE) begin
         if (hit(WB_ADR_I, flash_erase_pkg::OFS_ADDR_LOW)) begin
            addr_low_ff <= WB_DAT_I[7:0];
         end
         if (hit(WB_ADR_I, flash_erase_pkg::OFS_ADDR_HIGH)) begin
            addr_high_ff <= WB_DAT_I[6:0];
         end
      end
   end

   // Unlock tracker: any other bus write breaks the sequence
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         unlock_ff <= flash_erase_pkg::UNLOCK_IDLE;
      end else if (CLK_EN && wr_acc) begin
         if (wr_low && hit(WB_ADR_I, flash_erase_pkg::OFS_UNLOCK)) begin
            if (WB_DAT_I[7:0] == flash_erase_pkg::UNLOCK_FIRST) begin
               unlock_ff <= flash_erase_pkg::UNLOCK_HALF;
            end else if (WB_DAT_I[7:0] == flash_erase_pkg::UNLOCK_SECOND
               && unlock_ff == flash_erase_pkg::UNLOCK_HALF) begin
               unlock_ff <= flash_erase_pkg::UNLOCK_OPEN;
            end else begin
               unlock_ff <= flash_erase_pkg::UNLOCK_IDLE;
            end
         end else begin
            unlock_ff <= flash_erase_pkg::UNLOCK_IDLE;
         end
      end
   end

   // Control register
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         control_ff <= flash_erase_pkg::CONTROL_RESET;
      end else if (CLK_EN) begin
         if (seq_ff == flash_erase_pkg::SEQ_ERASE && count_ff == 22'h0) begin
            control_ff[flash_erase_pkg::BIT_START] <= 1'b0;
         end else if (wr_low && hit(WB_ADR_I, flash_erase_pkg::OFS_CONTROL)
            && seq_ff == flash_erase_pkg::SEQ_IDLE) begin
            control_ff <= nxt_control;
            control_ff[flash_erase_pkg::BIT_START] <= start_ok;
         end
      end
   end

   // Sequencer: setup, then timed erase
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         seq_ff <= flash_erase_pkg::SEQ_IDLE;
         count_ff <= 22'h0;
      end else if (CLK_EN) begin
         unique case (seq_ff)
            flash_erase_pkg::SEQ_IDLE: begin
               if (start_ok) begin
                  seq_ff <= flash_erase_pkg::SEQ_SETUP;
                  count_ff <= 22'(flash_erase_pkg::SETUP_CYCLES - 1);
               end
            end
            flash_erase_pkg::SEQ_SETUP: begin
               if (count_ff == 22'h0) begin
                  seq_ff <= flash_erase_pkg::SEQ_ERASE;
                  count_ff <= 22'(ERASE_CYCLES - 1);
               end else begin
                  count_ff <= count_ff - 22'h1;
               end
            end
            flash_erase_pkg::SEQ_ERASE: begin
               if (count_ff == 22'h0) begin
                  seq_ff <= flash_erase_pkg::SEQ_IDLE;
               end else begin
                  count_ff <= count_ff - 22'h1;
               end
            end
         endcase
      end
   end

   // Row request latched at start
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         req_ff <= '0;
      end else if (CLK_EN) begin
         if (start_ok) begin
            req_ff.valid <= 1'b1;
            req_ff.row_base <= {full_addr[14:flash_erase_pkg::ROW_WORDS_LOG2],
               {flash_erase_pkg::ROW_WORDS_LOG2{1'b0}}};
         end else if (seq_ff == flash_erase_pkg::SEQ_IDLE) begin
            req_ff.valid <= 1'b0;
         end
      end
   end

   // Stall and erase strobes
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         stall_ff <= 1'b0;
         erase_en_ff <= 1'b0;
      end else if (CLK_EN) begin
         stall_ff <= (seq_ff == flash_erase_pkg::SEQ_SETUP && count_ff == 22'h0)
            || (seq_ff == flash_erase_pkg::SEQ_ERASE && count_ff != 22'h0);
         erase_en_ff <= (seq_ff == flash_erase_pkg::SEQ_SETUP && count_ff == 22'h0)
            || (seq_ff == flash_erase_pkg::SEQ_ERASE && count_ff != 22'h0);
      end
   end

   assign WB_ACK_O = ack_ff;
   assign WB_DAT_O = rdata_ff;
   assign CPU_STALL = stall_ff;
   assign SLEEP_REQ = 1'b0;
   assign ERASE_EN = erase_en_ff;
   assign ERASE_ROW = req_ff.row_base;
   assign ERASE_CFG_SPACE = control_ff[flash_erase_pkg::BIT_CFG_SEL];
endmodule

// ---- pkg/flash_erase_pkg.sv ----
// Purpose: Shared constants and carriers for the row erase sequencer
// Assumes: 40 MHz system clock, classic Wishbone register access
// Notes: Register offsets are byte addresses of aligned words
package flash_erase_pkg;
   localparam int unsigned CLK_HZ = 40000000;
   localparam int unsigned ERASE_TIME_US = 2000;
   localparam int unsigned ERASE_CYCLES = (ERASE_TIME_US * (CLK_HZ / 1000000));
   localparam int unsigned SETUP_CYCLES = 2;
   localparam int unsigned ROW_WORDS_LOG2 = 5;

   localparam logic [7:0] OFS_ADDR_LOW = 8'h00;
   localparam logic [7:0] OFS_ADDR_HIGH = 8'h04;
   localparam logic [7:0] OFS_CONTROL = 8'h08;
   localparam logic [7:0] OFS_UNLOCK = 8'h0c;

   localparam int unsigned BIT_START = 1;
   localparam int unsigned BIT_MODIFY_EN = 2;
   localparam int unsigned BIT_ROW_ERASE = 4;
   localparam int unsigned BIT_CFG_SEL = 6;

   localparam logic [7:0] UNLOCK_FIRST = 8'h55;
   localparam logic [7:0] UNLOCK_SECOND = 8'haa;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] ADDR_RESET = 8'h00;

   typedef enum logic [1:0] {
      UNLOCK_IDLE,
      UNLOCK_HALF,
      UNLOCK_OPEN
   } unlock_t;

   typedef enum logic [1:0] {
      SEQ_IDLE,
      SEQ_SETUP,
      SEQ_ERASE
   } seq_t;

   typedef struct packed {
      logic valid;
      logic [14:0] row_base;
   } erase_req_t;
endpackage

// ---- verif/flash_erase_asserts.sv ----
// Purpose: Port timing checks for the row erase sequencer
// Assumes: CLK_EN held high while checked
// Notes: Bound into every sequencer instance
module flash_erase_asserts #(
   parameter int unsigned ERASE_CYCLES = 20
) (
   input wire logic SYS_CLK,
   input wire logic SRST,
   input wire logic CLK_EN,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic WB_ACK_O,
   input wire logic CPU_STALL,
   input wire logic SLEEP_REQ,
   input wire logic ERASE_EN,
   input wire logic [14:0] ERASE_ROW
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam int W = ERASE_CYCLES;
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (SRST);
   property p_ack; WB_CYC_I && WB_STB_I && !WB_ACK_O && CLK_EN |=> WB_ACK_O; endproperty
   a_ack: assert property (p_ack) else $error("ack missing");
   property p_pulse; WB_ACK_O |=> !WB_ACK_O; endproperty
   a_pulse: assert property (p_pulse) else $error("ack too long");
   property p_sleep; !SLEEP_REQ; endproperty
   a_sleep: assert property (p_sleep) else $error("sleep requested");
   property p_same; CPU_STALL == ERASE_EN; endproperty
   a_same: assert property (p_same) else $error("stall and erase differ");
   property p_row; ERASE_EN |-> ERASE_ROW[4:0] == 5'h00; endproperty
   a_row: assert property (p_row) else $error("row not aligned");
   property p_hold; ERASE_EN && $past(ERASE_EN) |-> $stable(ERASE_ROW); endproperty
   a_hold: assert property (p_hold) else $error("row moved");
   property p_len; $rose(CPU_STALL) |-> CPU_STALL[*8] ##[1:W] !CPU_STALL; endproperty
   a_len: assert property (p_len) else $error("stall length");
   property p_setup; $rose(CPU_STALL) |->
      $past(WB_ACK_O, 2) && $past(WB_ADR_I, 2) == flash_erase_pkg::OFS_CONTROL; endproperty
   a_setup: assert property (p_setup) else $error("setup delay");
endmodule
bind flash_row_erase_sequencer flash_erase_asserts #(.ERASE_CYCLES(ERASE_CYCLES)) i_chk (
   .SYS_CLK(SYS_CLK), .SRST(SRST), .CLK_EN(CLK_EN), .WB_CYC_I(WB_CYC_I),
   .WB_STB_I(WB_STB_I), .WB_ADR_I(WB_ADR_I), .WB_ACK_O(WB_ACK_O), .CPU_STALL(CPU_STALL),
   .SLEEP_REQ(SLEEP_REQ), .ERASE_EN(ERASE_EN), .ERASE_ROW(ERASE_ROW)
);

// ---- verif/tb_top.sv ----
// Purpose: Self-checking bench for the row erase sequencer
// Assumes: Erase count shortened to 20 cycles
// Notes: Row addresses from an xorshift source
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int unsigned EC = 20;
   localparam logic [7:0] CT = flash_erase_pkg::OFS_CONTROL;
   localparam logic [7:0] UL = flash_erase_pkg::OFS_UNLOCK;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic clk_en = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [3:0] sel = 4'h0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h00000000;
   logic [31:0] rdat, rd;
   logic ack, stall, sleep_req, erase_en, cfg, good;
   logic [14:0] row, exp_row;
   logic [31:0] seed = 32'h0000c53b;
   int mismatches = 0;
   int comparisons = 0;
   int n;
   always #12.5 sys_clk = ~sys_clk;
   flash_row_erase_sequencer #(.ERASE_CYCLES(EC)) i_dut (.SYS_CLK(sys_clk), .SRST(srst),
      .CLK_EN(clk_en), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
      .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .CPU_STALL(stall),
      .SLEEP_REQ(sleep_req), .ERASE_EN(erase_en), .ERASE_ROW(row), .ERASE_CFG_SPACE(cfg));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      sel <= 4'hf;
      do begin
         @(posedge sys_clk);
         k++;
      end while (ack !== 1'b1 && k < 50);
      if (k >= 50) mismatches++;
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      #(25 * 4000);
      mismatches++;
      finish_test();
   end
   initial begin
      repeat (8) @(posedge sys_clk);
      srst <= 1'b0;
      @(posedge sys_clk);
      for (int a = 0; a < 5; a++) begin
         wb(1'b0, 8'(a * 4), 32'h0);
         chk(rd, 32'h0);
      end
      wb(1'b1, CT, 32'h00000054);
      chk({31'h0, cfg}, 32'h1);
      $display("test reset done");
      for (int k = 0; k < 7; k++) begin
         seed = xs(seed);
         good = (k >= 4);
         exp_row = seed[14:0] & 15'h7fe0;
         wb(1'b1, flash_erase_pkg::OFS_ADDR_LOW, {24'h0, seed[7:0]});
         wb(1'b1, flash_erase_pkg::OFS_ADDR_HIGH, {25'h0, seed[14:8]});
         wb(1'b1, CT, (k == 3) ? 32'h10 : 32'h14);
         if (k != 0) wb(1'b1, UL, (k == 1) ? 32'haa : 32'h55);
         if (k == 2) wb(1'b1, flash_erase_pkg::OFS_ADDR_LOW, 32'h0);
         if (k != 0) wb(1'b1, UL, (k == 1) ? 32'h55 : 32'haa);
         wb(1'b1, CT, (k == 3) ? 32'h12 : 32'h16);
         n = 0;
         while (stall !== 1'b1 && n < 8) begin
            @(posedge sys_clk);
            n++;
         end
         chk({31'h0, stall}, {31'h0, good});
         chk({31'h0, erase_en}, {31'h0, good});
         if (good) begin
            chk({17'h0, row}, {17'h0, exp_row});
            chk({31'h0, sleep_req}, 32'h0);
            wb(1'b0, CT, 32'h0);
            chk({31'h0, rd[1]}, 32'h1);
            wb(1'b1, flash_erase_pkg::OFS_ADDR_LOW, 32'h0000005a);
            while (stall === 1'b1 && n < EC + 20) begin
               @(posedge sys_clk);
               n++;
            end
            wb(1'b0, flash_erase_pkg::OFS_ADDR_LOW, 32'h0);
            chk(rd, {24'h0, seed[7:0]});
         end
         wb(1'b0, CT, 32'h0);
         chk({31'h0, rd[1]}, 32'h0);
         $display("test %0d done", k);
      end
      finish_test();
   end
endmodule
